/* File: common/btm_defs.svh */
// Constants of the bit test / set / masked compare block.
// Assumes inclusion by bare name from the package and design files.
`ifndef BTM_DEFS_SVH
`define BTM_DEFS_SVH

// Bus widths and address split
`define BTM_AW          16
`define BTM_DW          16
`define BTM_RGN_MSB     15
`define BTM_RGN_LSB     12
`define BTM_OFF_MSB     11
`define BTM_OFF_W       12

// Address regions
`define BTM_RGN_REG     4'h0
`define BTM_RGN_BITS    4'h1
`define BTM_RGN_FIRST   4'h2
`define BTM_RGN_SECOND  4'h3
`define BTM_RGN_MASK    4'h4
`define BTM_RGN_RESULT  4'h5

// Register offsets inside the register region
`define BTM_OFF_CMD      12'h000
`define BTM_OFF_BIT_LEN  12'h001
`define BTM_OFF_BIT_SEL  12'h002
`define BTM_OFF_MC_LEN   12'h003
`define BTM_OFF_MC_START 12'h004
`define BTM_OFF_STATUS   12'h005
`define BTM_OFF_LAST_POS 12'h006

// Command word fields
`define BTM_CMD_EN      0
`define BTM_CMD_OP_MSB  2
`define BTM_CMD_OP_LSB  1

// Status word fields
`define BTM_ST_RESULT   0
`define BTM_ST_OK       1
`define BTM_ST_MISCMP   2
`define BTM_ST_BUSY     3
`define BTM_ST_RESTART  4

// String geometry
`define BTM_WORD_BITS   16
`define BTM_BIT_LOG     4
`define BTM_BT_WORDS    256
`define BTM_BT_IDX_W    8
`define BTM_BT_LEN_W    9
`define BTM_MC_WORDS    4095
`define BTM_MC_IDX_W    12

// Reset values
`define BTM_BIT_LEN_RST  9'h001
`define BTM_BIT_SEL_RST  16'h0001
`define BTM_MC_LEN_RST   12'h001
`define BTM_MC_START_RST 16'h0000

`endif

/* File: common/btm_pkg.sv */
// Types shared by the bit operation block.
// Assumes btm_defs.svh is on the include path.
`include "btm_defs.svh"

package btm_pkg;

  // Operation selected by a command write
  typedef enum logic [1:0] {
    BTM_OP_TEST  = 2'b00,
    BTM_OP_SET   = 2'b01,
    BTM_OP_CLEAR = 2'b10,
    BTM_OP_MCMP  = 2'b11
  } btm_op_t;

  // Masked compare sequencer
  typedef enum logic {
    BTM_MC_IDLE = 1'b0,
    BTM_MC_SCAN = 1'b1
  } btm_mc_state_t;

  typedef logic [`BTM_DW-1:0] btm_word_t;

endpackage : btm_pkg

/* File: common/btm_core_if.sv */
// Internal carrier between the top, the bit unit and the compare engine.
// Assumes a single clock domain; all signals are plain levels.
`timescale 1ns/10ps
`default_nettype none
`include "btm_defs.svh"

interface btm_core_if;
  import btm_pkg::*;

  // Bit test / set / clear group
  btm_word_t                 bt_word;
  logic [`BTM_DW-1:0]        bt_sel;
  logic [`BTM_BT_LEN_W-1:0]  bt_len;
  logic [`BTM_BT_IDX_W-1:0]  bt_widx;
  logic                      bt_in_range;
  logic                      bt_bit;
  btm_word_t                 bt_set_word;
  btm_word_t                 bt_clr_word;

  // Masked compare group
  logic                      mc_start;
  logic [`BTM_MC_IDX_W-1:0]  mc_len;
  logic [`BTM_DW-1:0]        mc_start_pos;
  logic [`BTM_MC_IDX_W-1:0]  mc_ridx;
  btm_word_t                 mc_a;
  btm_word_t                 mc_b;
  btm_word_t                 mc_m;
  logic                      mc_mwe;
  btm_word_t                 mc_mword;
  logic                      mc_busy;
  logic                      mc_miscompare;
  logic                      mc_restart;
  logic [`BTM_DW-1:0]        mc_last_pos;

  modport top_bit (output bt_word, bt_sel, bt_len,
                   input bt_widx, bt_in_range, bt_bit, bt_set_word,
                   bt_clr_word);
  modport bit_unit (input bt_word, bt_sel, bt_len,
                    output bt_widx, bt_in_range, bt_bit, bt_set_word,
                    bt_clr_word);
  modport top_mc (output mc_start, mc_len, mc_start_pos, mc_a, mc_b, mc_m,
                  input mc_ridx, mc_mwe, mc_mword, mc_busy, mc_miscompare,
                  mc_restart, mc_last_pos);
  modport mc_eng (input mc_start, mc_len, mc_start_pos, mc_a, mc_b, mc_m,
                  output mc_ridx, mc_mwe, mc_mword, mc_busy, mc_miscompare,
                  mc_restart, mc_last_pos);
endinterface : btm_core_if

`default_nettype wire

/* File: rtl/btm_bit_unit.sv */
// Combinational bit selector for test, set and clear.
// Assumes the top returns the word addressed by bt_widx in bt_word.
`timescale 1ns/10ps
`default_nettype none
`include "btm_defs.svh"

module btm_bit_unit (
  btm_core_if.bit_unit core
);
  import btm_pkg::*;

  logic [`BTM_DW-1:0]      zsel;
  logic [`BTM_BIT_LOG-1:0] bsel;
  logic [`BTM_DW-1:0]      nbits;
  btm_word_t               onehot;

  // ---------------------------------------------------------------
  // Position decode
  // ---------------------------------------------------------------
  // One-based selector to zero-based bit number
  always_comb begin
    zsel  = core.bt_sel - `BTM_DW'(1);
    bsel  = zsel[`BTM_BIT_LOG-1:0];
    nbits = {3'h0, core.bt_len, 4'h0};
    core.bt_widx = zsel[`BTM_BIT_LOG+`BTM_BT_IDX_W-1:`BTM_BIT_LOG];
    core.bt_in_range = (core.bt_sel != `BTM_DW'(0)) &&
                       (core.bt_sel <= nbits);
    onehot = btm_word_t'(1) << bsel;
  end

  // ---------------------------------------------------------------
  // Bit value and modified words
  // ---------------------------------------------------------------
  always_comb begin
    core.bt_bit      = core.bt_word[bsel];
    core.bt_set_word = core.bt_word | onehot;
    core.bt_clr_word = core.bt_word & ~onehot;
  end

endmodule : btm_bit_unit

`default_nettype wire

/* File: rtl/btm_mc_engine.sv */
// Masked compare sequencer, one bit examined per clock.
// Assumes the top returns operand and mask words at mc_ridx
// combinationally and writes mc_mword into the mask when mc_mwe.
`timescale 1ns/10ps
`default_nettype none
`include "btm_defs.svh"

module btm_mc_engine (
  input  wire logic  core_clk,
  input  wire logic  rstn,
  btm_core_if.mc_eng core
);
  import btm_pkg::*;

  btm_mc_state_t      state, next_state;
  logic [`BTM_DW-1:0] pos, next_pos;
  logic [`BTM_DW-1:0] nbits, next_nbits;
  logic               miscmp, next_miscmp;
  logic               restart, next_restart;
  logic [`BTM_DW-1:0] last, next_last;
  logic               a_bit, b_bit, m_bit;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_pos     = pos;
    next_nbits   = nbits;
    next_miscmp  = miscmp;
    next_restart = restart;
    next_last    = last;
    core.mc_mwe  = 1'b0;
    a_bit = core.mc_a[pos[`BTM_BIT_LOG-1:0]];
    b_bit = core.mc_b[pos[`BTM_BIT_LOG-1:0]];
    m_bit = core.mc_m[pos[`BTM_BIT_LOG-1:0]];
    core.mc_mword = core.mc_m |
                    (btm_word_t'(1) << pos[`BTM_BIT_LOG-1:0]);
    unique case (state)
      BTM_MC_IDLE: begin
        if (core.mc_start) begin
          next_nbits = {core.mc_len, 4'h0};
          // Zero-based start, wrapped or restarted from the first bit
          if (restart || core.mc_start_pos >= next_nbits) begin
            next_pos = `BTM_DW'(0);
          end else begin
            next_pos = core.mc_start_pos;
          end
          next_state = BTM_MC_SCAN;
        end
      end
      BTM_MC_SCAN: begin
        if (a_bit != b_bit && !m_bit) begin
          // Unmasked mismatch: latch into mask and stop
          core.mc_mwe  = 1'b1;
          next_miscmp  = 1'b1;
          next_last    = pos + `BTM_DW'(1);
          next_restart = 1'b0;
          next_state   = BTM_MC_IDLE;
        end else if (pos == nbits - `BTM_DW'(1)) begin
          // Last bit done with no new mismatch
          next_miscmp  = 1'b0;
          next_last    = nbits;
          next_restart = 1'b1;
          next_state   = BTM_MC_IDLE;
        end else begin
          next_pos = pos + `BTM_DW'(1);
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state   <= BTM_MC_IDLE;
      pos     <= `BTM_DW'(0);
      nbits   <= `BTM_DW'(0);
      miscmp  <= 1'b0;
      restart <= 1'b0;
      last    <= `BTM_DW'(0);
    end else begin
      state   <= next_state;
      pos     <= next_pos;
      nbits   <= next_nbits;
      miscmp  <= next_miscmp;
      restart <= next_restart;
      last    <= next_last;
    end
  end

  // Outputs toward the top
  always_comb begin
    core.mc_ridx       = pos[`BTM_DW-1:`BTM_BIT_LOG];
    core.mc_busy       = (state == BTM_MC_SCAN);
    core.mc_miscompare = miscmp;
    core.mc_restart    = restart;
    core.mc_last_pos   = last;
  end

endmodule : btm_mc_engine

`default_nettype wire

/* File: rtl/btm_top.sv */
// Top of the bit test / set / clear / masked compare block.
// Assumes a register master that follows the strobe timing of the plain
// port; one command write stands for one enabled scan of an operation.
//
// Functional notes
// - Bit test acts only on enabled command
// - Test result equals selected bit value
// - Out-of-range test selector forces result low
// - Set writes one, clear writes zero
// - Set/clear act each enabled scan, current selector
// - Ok high only when enabled and in range
// - Compare starts on enable, ascending bit order
// - Stops at unmasked mismatch or final bit
// - Compare start position is zero-based
// - Last position reported one-based
// - Start beyond string end replaced by zero
// - Full match clears miscompare, reports highest bit
// - After full match next compare restarts at zero
// - Masked mismatch ignored, compare continues
// - Unmasked mismatch sets mask bit, flag, stops
// - Result string always mirrors mask contents
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "btm_defs.svh"

module btm_top (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [`BTM_AW-1:0] reg_addr,
  input  wire btm_pkg::btm_word_t reg_wdata,
  input  wire logic             reg_we,
  input  wire logic             reg_re,
  output var  btm_pkg::btm_word_t reg_rdata,
  output var  logic             result_flag,
  output var  logic             ok_flag,
  output var  logic             miscompare_flag,
  output var  logic [`BTM_DW-1:0] last_position_out,
  output var  logic             busy
);
  import btm_pkg::*;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Region field test
  function automatic logic in_rgn(input logic [`BTM_AW-1:0] a,
                                  input logic [3:0] rgn);
    in_rgn = (a[`BTM_RGN_MSB:`BTM_RGN_LSB] == rgn);
  endfunction : in_rgn

  // Top word slot unmapped
  function automatic logic mc_idx_ok(input logic [`BTM_AW-1:0] a);
    mc_idx_ok = (a[`BTM_OFF_MSB:0] < `BTM_OFF_W'(`BTM_MC_WORDS));
  endfunction : mc_idx_ok

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Strings have no reset
  btm_word_t bit_mem    [`BTM_BT_WORDS];
  btm_word_t first_mem  [`BTM_MC_WORDS];
  btm_word_t second_mem [`BTM_MC_WORDS];
  btm_word_t mask_mem   [`BTM_MC_WORDS];

  btm_core_if core ();

  logic [`BTM_BT_LEN_W-1:0] bit_len;
  logic [`BTM_BT_LEN_W-1:0] next_bit_len;
  logic [`BTM_DW-1:0]       bit_sel;
  logic [`BTM_DW-1:0]       next_bit_sel;
  logic [`BTM_MC_IDX_W-1:0] mc_len;
  logic [`BTM_MC_IDX_W-1:0] next_mc_len;
  logic [`BTM_DW-1:0]       mc_start;
  logic [`BTM_DW-1:0]       next_mc_start;
  logic                     next_result;
  logic                     next_ok;
  btm_word_t                next_rdata;

  // Decode and steering
  logic [`BTM_OFF_W-1:0]    off;
  logic                     reg_wr;
  logic                     cmd_wr;
  logic                     cmd_en;
  btm_op_t                  cmd_op;
  logic                     bit_we;
  logic [`BTM_BT_IDX_W-1:0] bit_widx;
  btm_word_t                bit_wdata;
  logic                     host_mc_wr;
  logic                     mc_idle_wr;

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  btm_bit_unit u_bit (
    .core (core.bit_unit)
  );

  btm_mc_engine u_mc (
    .core_clk (core_clk),
    .rstn     (rstn),
    .core     (core.mc_eng)
  );

  // Feed the sub-blocks
  always_comb begin
    core.bt_sel       = bit_sel;
    core.bt_len       = bit_len;
    core.bt_word      = bit_mem[core.bt_widx];
    core.mc_len       = mc_len;
    core.mc_start_pos = mc_start;
    core.mc_a         = first_mem[core.mc_ridx];
    core.mc_b         = second_mem[core.mc_ridx];
    core.mc_m         = mask_mem[core.mc_ridx];
    core.mc_start     = cmd_wr && cmd_en && (cmd_op == BTM_OP_MCMP) &&
                        !core.mc_busy;
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  always_comb begin
    off    = reg_addr[`BTM_OFF_MSB:0];
    reg_wr = reg_we && in_rgn(reg_addr, `BTM_RGN_REG);
    cmd_wr = reg_wr && (off == `BTM_OFF_CMD);
    cmd_en = reg_wdata[`BTM_CMD_EN];
    cmd_op = btm_op_t'(reg_wdata[`BTM_CMD_OP_MSB:`BTM_CMD_OP_LSB]);
    mc_idle_wr = reg_we && !core.mc_busy && mc_idx_ok(reg_addr);
    host_mc_wr = mc_idle_wr && in_rgn(reg_addr, `BTM_RGN_MASK);
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_comb begin
    next_bit_len  = bit_len;
    next_bit_sel  = bit_sel;
    next_mc_len   = mc_len;
    next_mc_start = mc_start;
    if (reg_wr) begin
      unique case (off)
        `BTM_OFF_BIT_LEN:  next_bit_len = reg_wdata[`BTM_BT_LEN_W-1:0];
        `BTM_OFF_BIT_SEL:  next_bit_sel = reg_wdata;
        `BTM_OFF_MC_LEN: begin
          if (!core.mc_busy) begin
            next_mc_len = reg_wdata[`BTM_MC_IDX_W-1:0];
          end
        end
        `BTM_OFF_MC_START: next_mc_start = reg_wdata;
        default: ;
      endcase
    end
  end

  // Reset values
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_len  <= `BTM_BIT_LEN_RST;
      bit_sel  <= `BTM_BIT_SEL_RST;
      mc_len   <= `BTM_MC_LEN_RST;
      mc_start <= `BTM_MC_START_RST;
    end else begin
      bit_len  <= next_bit_len;
      bit_sel  <= next_bit_sel;
      mc_len   <= next_mc_len;
      mc_start <= next_mc_start;
    end
  end

  // ---------------------------------------------------------------
  // Test result and ok flags
  // ---------------------------------------------------------------
  always_comb begin
    next_result = result_flag;
    next_ok     = ok_flag;
    if (cmd_wr && cmd_en && cmd_op == BTM_OP_TEST) begin
      next_result = core.bt_in_range && core.bt_bit;
    end
    if (cmd_wr && (cmd_op == BTM_OP_SET || cmd_op == BTM_OP_CLEAR)) begin
      next_ok = cmd_en && core.bt_in_range;
    end
  end

  // Flags hold between commands
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      result_flag <= 1'b0;
      ok_flag     <= 1'b0;
    end else begin
      result_flag <= next_result;
      ok_flag     <= next_ok;
    end
  end

  // ---------------------------------------------------------------
  // Bit string writes: host load or set/clear
  // ---------------------------------------------------------------
  always_comb begin
    bit_we    = 1'b0;
    bit_widx  = reg_addr[`BTM_BT_IDX_W-1:0];
    bit_wdata = reg_wdata;
    if (cmd_wr && cmd_en && core.bt_in_range &&
        (cmd_op == BTM_OP_SET || cmd_op == BTM_OP_CLEAR)) begin
      bit_we    = 1'b1;
      bit_widx  = core.bt_widx;
      if (cmd_op == BTM_OP_SET) begin
        bit_wdata = core.bt_set_word;
      end else begin
        bit_wdata = core.bt_clr_word;
      end
    end else if (reg_we && in_rgn(reg_addr, `BTM_RGN_BITS) &&
                 off < `BTM_OFF_W'(`BTM_BT_WORDS)) begin
      bit_we = 1'b1;
    end
  end

  // Set/clear beat host loads
  always_ff @(posedge core_clk) begin
    if (bit_we) begin
      bit_mem[bit_widx] <= bit_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Compare strings: host loads while idle, engine latches mask bits
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (mc_idle_wr && in_rgn(reg_addr, `BTM_RGN_FIRST)) begin
      first_mem[off] <= reg_wdata;
    end
    if (mc_idle_wr && in_rgn(reg_addr, `BTM_RGN_SECOND)) begin
      second_mem[off] <= reg_wdata;
    end
    if (core.mc_mwe) begin
      mask_mem[core.mc_ridx] <= core.mc_mword;
    end else if (host_mc_wr) begin
      mask_mem[off] <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Read data, valid the cycle after the read strobe
  // ---------------------------------------------------------------
  // Holes read zero
  always_comb begin
    next_rdata = btm_word_t'(0);
    if (reg_re) begin
      if (in_rgn(reg_addr, `BTM_RGN_REG)) begin
        unique case (off)
          `BTM_OFF_BIT_LEN:  next_rdata = btm_word_t'(bit_len);
          `BTM_OFF_BIT_SEL:  next_rdata = bit_sel;
          `BTM_OFF_MC_LEN:   next_rdata = btm_word_t'(mc_len);
          `BTM_OFF_MC_START: next_rdata = mc_start;
          `BTM_OFF_STATUS: begin
            next_rdata[`BTM_ST_RESULT]  = result_flag;
            next_rdata[`BTM_ST_OK]      = ok_flag;
            next_rdata[`BTM_ST_MISCMP]  = core.mc_miscompare;
            next_rdata[`BTM_ST_BUSY]    = core.mc_busy;
            next_rdata[`BTM_ST_RESTART] = core.mc_restart;
          end
          `BTM_OFF_LAST_POS: next_rdata = core.mc_last_pos;
          default: ;
        endcase
      end else if (in_rgn(reg_addr, `BTM_RGN_BITS)) begin
        if (off < `BTM_OFF_W'(`BTM_BT_WORDS)) begin
          next_rdata = bit_mem[off[`BTM_BT_IDX_W-1:0]];
        end
      end else if (mc_idx_ok(reg_addr)) begin
        if (in_rgn(reg_addr, `BTM_RGN_FIRST)) begin
          next_rdata = first_mem[off];
        end else if (in_rgn(reg_addr, `BTM_RGN_SECOND)) begin
          next_rdata = second_mem[off];
        end else if (in_rgn(reg_addr, `BTM_RGN_MASK) ||
                     in_rgn(reg_addr, `BTM_RGN_RESULT)) begin
          next_rdata = mask_mem[off];
        end
      end
    end
  end

  // One-cycle read data
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= btm_word_t'(0);
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Engine status straight from its flops
  always_comb begin
    miscompare_flag   = core.mc_miscompare;
    last_position_out = core.mc_last_pos;
    busy              = core.mc_busy;
  end

endmodule : btm_top

`default_nettype wire

/* File: verif/btm_top_props.sv */
// Port assertions for the bit operation block.
// Assumes a bind onto btm_top; one clock, reset low.
`timescale 1ns/10ps
`default_nettype none
`include "btm_defs.svh"

module btm_props
  import btm_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rstn,
  input wire logic [`BTM_AW-1:0] reg_addr,
  input wire btm_pkg::btm_word_t reg_wdata,
  input wire logic               reg_we,
  input wire logic               reg_re,
  input wire btm_pkg::btm_word_t reg_rdata,
  input wire logic               result_flag,
  input wire logic               ok_flag,
  input wire logic               miscompare_flag,
  input wire logic [`BTM_DW-1:0] last_position_out,
  input wire logic               busy
);
  logic [8:0]  bit_len, next_bit_len;
  logic [15:0] bit_sel, next_bit_sel;
  logic [11:0] mc_len, next_mc_len;
  logic [16:0] scan_cnt, next_scan_cnt;
  wire logic cmd_wr = reg_we && reg_addr == 16'h0000;
  wire logic sel_ok = bit_sel != 16'h0 &&
                      {1'b0, bit_sel} <= {4'h0, bit_len, 4'h0};

  // Shadow of lengths and selector, busy cycle count
  always_comb begin
    next_bit_len = bit_len;
    next_bit_sel = bit_sel;
    next_mc_len = mc_len;
    if (reg_we && reg_addr == 16'h0001) next_bit_len = reg_wdata[8:0];
    if (reg_we && reg_addr == 16'h0002) next_bit_sel = reg_wdata;
    if (reg_we && reg_addr == 16'h0003 && !busy) next_mc_len = reg_wdata[11:0];
    next_scan_cnt = busy ? scan_cnt + 17'h1 : 17'h0;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_len <= 9'h001;
      bit_sel <= 16'h0001;
      mc_len <= 12'h001;
      scan_cnt <= 17'h0;
    end else begin
      bit_len <= next_bit_len;
      bit_sel <= next_bit_sel;
      mc_len <= next_mc_len;
      scan_cnt <= next_scan_cnt;
    end
  end

  // ------
  // Properties
  // ------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence mc_launch;
    cmd_wr && reg_wdata[2:0] == 3'h7 && !busy;
  endsequence
  sequence mc_full;
    $fell(busy) ##0 !miscompare_flag;
  endsequence
  sequence mc_miss;
    $fell(busy) ##0 miscompare_flag;
  endsequence

  a_test_range: assert property (
    cmd_wr && reg_wdata[2:0] == 3'h1 && !sel_ok |=> !result_flag)
    else $error("test out of range not low");
  a_test_idle: assert property (
    cmd_wr && reg_wdata[2:0] == 3'h0 |=> $stable(result_flag))
    else $error("disabled test moved");
  a_ok_high: assert property (cmd_wr && reg_wdata[0] && sel_ok &&
    reg_wdata[2:1] inside {2'b01, 2'b10} |=> ok_flag)
    else $error("ok missing");
  a_ok_low: assert property (cmd_wr && !(reg_wdata[0] && sel_ok) &&
    reg_wdata[2:1] inside {2'b01, 2'b10} |=> !ok_flag)
    else $error("ok wrongly high");
  a_mc_launch: assert property (mc_launch |=> busy)
    else $error("compare did not start");
  a_scan_bound: assert property (scan_cnt <= {1'b0, mc_len, 4'h0})
    else $error("scan ran past final bit");
  a_full_pos: assert property (mc_full |->
    last_position_out == {mc_len, 4'h0}) else $error("bad end pos");
  a_miss_pos: assert property (mc_miss |->
    last_position_out != 16'h0 && last_position_out <= {mc_len, 4'h0})
    else $error("bad pos");
  a_flag_change: assert property (
    $changed(miscompare_flag) |-> $fell(busy))
    else $error("flag moved outside stop");
endmodule : btm_props

bind btm_top btm_props u_props (.core_clk(core_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .result_flag(result_flag),
  .ok_flag(ok_flag), .miscompare_flag(miscompare_flag),
  .last_position_out(last_position_out), .busy(busy));

`default_nettype wire

/* File: verif/btm_scan_model.sv */
// Program scan model: drives the plain register port.
// Assumes reads answer one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
`include "btm_defs.svh"

module btm_scan_model
  import btm_pkg::*;
(
  input  wire logic               core_clk,
  output var  logic [`BTM_AW-1:0] reg_addr,
  output var  btm_pkg::btm_word_t reg_wdata,
  output var  logic               reg_we,
  output var  logic               reg_re,
  input  wire btm_pkg::btm_word_t reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr = 16'h0;
    reg_wdata = 16'h0;
    reg_we = 1'b0;
    reg_re = 1'b0;
  end

  // One-cycle write; released lines do not keep their value
  task automatic wr(input logic [15:0] a, input btm_word_t d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // One-cycle read, data taken in the following cycle
  task automatic rd(input logic [15:0] a, output btm_word_t d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    reg_addr <= ~a;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : btm_scan_model

`default_nettype wire

/* File: verif/btm_top_test.sv */
// Self-checking bench for the bit operation block.
// Assumes btm_props is bound and btm_scan_model drives the bus.
`timescale 1ns/10ps
`default_nettype none
`include "btm_defs.svh"

module btm_top_test;
  import btm_pkg::*;
  logic               core_clk = 1'b0;
  logic               rstn = 1'b0;
  logic [`BTM_AW-1:0] reg_addr;
  btm_word_t          reg_wdata, reg_rdata, rd_val;
  logic               reg_we, reg_re, result_flag, ok_flag;
  logic               miscompare_flag, busy;
  logic [`BTM_DW-1:0] last_position_out;
  int                 err_total = 0;
  int                 n_checks = 0;

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  btm_top DUT (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .result_flag(result_flag), .ok_flag(ok_flag),
    .miscompare_flag(miscompare_flag), .busy(busy),
    .last_position_out(last_position_out));
  btm_scan_model u_scan (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata));

  // ------
  // Helpers
  // ------
  task automatic chk(input btm_word_t got, input btm_word_t exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input logic [2:0] c);
    u_scan.wr(16'h0000, {13'h0, c});
    @(negedge core_clk);
  endtask : cmd

  task automatic rchk(input logic [15:0] a, input btm_word_t exp);
    u_scan.rd(a, rd_val);
    chk(rd_val, exp);
  endtask : rchk

  task automatic mc_run(input btm_word_t st, input logic mc,
                        input btm_word_t pos, input btm_word_t mask);
    int n;
    u_scan.wr(16'h0004, st);
    cmd(3'h7);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk({15'h0, busy}, 16'h0);
    chk({15'h0, miscompare_flag}, {15'h0, mc});
    chk(last_position_out, pos);
    rchk(16'h4000, mask);
    rchk(16'h5000, mask);
  endtask : mc_run

  // ------
  // Scenarios
  // ------
  task automatic t_regs;
    rchk(16'h0001, 16'h0001);
    rchk(16'h0002, 16'h0001);
    rchk(16'h0003, 16'h0001);
    rchk(16'h0004, 16'h0000);
    rchk(16'h0007, 16'h0000);
  endtask : t_regs

  task automatic t_test;
    logic [15:0] sels [7] = '{16'h3, 16'h4, 16'h10, 16'h11, 16'h21, 16'h3,
                              16'h0};
    logic [6:0]  exps = 7'h2d;
    u_scan.wr(16'h1000, 16'h8004);
    u_scan.wr(16'h1001, 16'h0001);
    u_scan.wr(16'h0001, 16'h0002);
    for (int i = 0; i < 7; i++) begin
      u_scan.wr(16'h0002, sels[i]);
      cmd(3'h1);
      chk({15'h0, result_flag}, {15'h0, exps[i]});
    end
    u_scan.wr(16'h0002, 16'h3);
    cmd(3'h0);
    chk({15'h0, result_flag}, 16'h0);
  endtask : t_test

  task automatic t_setclr;
    u_scan.wr(16'h0002, 16'h10);
    cmd(3'h5);
    chk({15'h0, ok_flag}, 16'h1);
    rchk(16'h1000, 16'h0004);
    u_scan.wr(16'h0002, 16'h12);
    cmd(3'h3);
    rchk(16'h1001, 16'h0003);
    u_scan.wr(16'h0002, 16'h21);
    cmd(3'h3);
    chk({15'h0, ok_flag}, 16'h0);
    rchk(16'h1000, 16'h0004);
    rchk(16'h1001, 16'h0003);
    u_scan.wr(16'h0002, 16'h1);
    cmd(3'h2);
    chk({15'h0, ok_flag}, 16'h0);
    rchk(16'h1000, 16'h0004);
    cmd(3'h3);
    chk({15'h0, ok_flag}, 16'h1);
    rchk(16'h1000, 16'h0005);
  endtask : t_setclr

  task automatic t_mcmp;
    u_scan.wr(16'h0003, 16'h0001);
    u_scan.wr(16'h2000, 16'h6c6c);
    u_scan.wr(16'h3000, 16'h606f);
    u_scan.wr(16'h4000, 16'h000f);
    mc_run(16'h0000, 1'b1, 16'h000b, 16'h040f);
    mc_run(16'h000b, 1'b1, 16'h000c, 16'h0c0f);
    mc_run(16'h000c, 1'b0, 16'h0010, 16'h0c0f);
    u_scan.wr(16'h3000, 16'h604f);
    mc_run(16'h000c, 1'b1, 16'h0006, 16'h0c2f);
    u_scan.wr(16'h3000, 16'h605f);
    mc_run(16'h0020, 1'b1, 16'h0005, 16'h0c3f);
    rchk(16'h0005, 16'h0006);
    rchk(16'h0006, 16'h0005);
  endtask : t_mcmp

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_test();
    t_setclr();
    t_mcmp();
    give_verdict();
  end

  // Watchdog
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule : btm_top_test

`default_nettype wire
